// >>> iit_pkg.sv
// Package with register map, field positions and constants of the idle interval timer
`default_nettype none
package iit_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [11:0] IIT_OFS_PERIOD = 12'h000;
  localparam logic [11:0] IIT_OFS_IRQCTL = 12'h004;
  localparam logic [11:0] IIT_OFS_STATUS = 12'h008;
  localparam logic [11:0] IIT_OFS_MASK = 12'h00C;
  localparam logic [11:0] IIT_OFS_PORTG = 12'h010;
  // ==========================================
  // Field positions
  localparam int IIT_BIT_PENDING = 5;
  localparam int IIT_BIT_IRQEN = 4;
  localparam int IIT_BIT_GIE = 0;
  localparam int IIT_BIT_WAKE = 6;
  localparam int IIT_TAP_BASE = 11;
  // ==========================================
  // Reset values
  localparam logic [7:0] IIT_PERIOD_RST = 8'hF0;
  localparam logic [7:0] IIT_IRQCTL_RST = 8'h00;
  localparam logic [7:0] IIT_PORTG_RST = 8'hFF;
  localparam logic [15:0] IIT_COUNT_RST = 16'hFFFF;
  localparam logic [2:0] IIT_SEL_MAX = 3'h4;
  // ==========================================
  // Timing: 10 MHz system clock
  localparam int IIT_CLK_HZ = 10_000_000;
  localparam int IIT_SLOW_HZ = 32_768;
  localparam int IIT_SLOW_DIV = IIT_CLK_HZ / IIT_SLOW_HZ;
  localparam int IIT_CYC_DIV = 5;
  localparam int IIT_DIV_W = 9;
  // Status bits (sticky, write one to clear)
  localparam int IIT_ST_TICK = 0;
  localparam int IIT_ST_RESETREQ = 1;
  typedef enum logic [1:0] {IIT_MODE_FAST, IIT_MODE_DUAL, IIT_MODE_SLOW} iit_mode_t;
  typedef struct packed {
    logic slowOscOn;
    logic fastOscOn;
    logic dualClockEnable;
    logic coreClockSelect;
    logic rsvd;
    logic [2:0] idlePeriodSelect;
  } iit_period_t;
endpackage : iit_pkg
`default_nettype wire

// >>> iit_tick_gen.sv
// Clock-enable tick generator for the idle counter
`default_nettype none
module iit_tick_gen (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slowSel,
  output logic tick
);
  logic [iit_pkg::IIT_DIV_W-1:0] cnt;
  logic [iit_pkg::IIT_DIV_W-1:0] lim;
  // Fast path divides by five, slow path approximates 32 kHz
  assign lim = slowSel ? iit_pkg::IIT_DIV_W'(iit_pkg::IIT_SLOW_DIV - 1) : iit_pkg::IIT_DIV_W'(iit_pkg::IIT_CYC_DIV - 1);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= lim) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : iit_tick_gen
`default_nettype wire

// >>> idle_interval_timer.sv
// Idle interval timer with APB register access and interrupt
// Summary of operation
// R1: The idle counter is a 16-bit down counter that software cannot read or write.
// R2: In high-speed mode the counter advances at the instruction-cycle rate, one fifth of the input clock.
// R3: In dual-clock or low-speed mode the counter advances at the 32 kHz rate.
// R4: In dual-clock and low-speed mode the instruction-cycle divider is stopped.
// R5: The period select chooses counter bit 11 to 15 as the interval tap.
// R6: Each tap underflow sets the idle tick pending flag.
// R7: Each tap underflow clears bit 6 of the port G data register to wake the core.
// R8: The idle tick interrupt is requested only while pending, enable and global enable are all set.
// R9: Pending sits at bit 5 and its enable at bit 4 of the interrupt control register.
// R10: Select codes 0 to 4 give 4k to 64k counts; codes above 4 are reserved.
// R11: Reset clears the period select, giving the 4,096 interval.
// R12: Software keeps bit 3 of the period control register at zero.
// R13: Writing zero into the clock-mode bits forces a reset request.
// R14: Changing the period select may set the pending flag spuriously.
// R15: The counter also gives the watchdog tick and the start-up delay, done at the second tap underflow after reset.
// R16: Pending stays set until software writes zero and is set by any underflow.
`default_nettype none
module idle_interval_timer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic idleTickIrq,
  output logic wakeBit,
  output logic deviceResetReq,
  output logic watchdogTick,
  output logic startupDone
);
  // ==========================================
  // Registers
  iit_pkg::iit_period_t idlePeriodCtrlReg;
  logic [7:0] irqControlReg;
  logic [7:0] portGData;
  logic [1:0] status;
  logic [1:0] mask;
  logic [15:0] idleCounter;
  logic [15:0] next_idleCounter;
  iit_pkg::iit_mode_t mode;
  logic cntTick;
  logic tapUnderflow;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [4:0] startupCnt;
  logic resetEvent;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign mapped = paddr == iit_pkg::IIT_OFS_PERIOD || paddr == iit_pkg::IIT_OFS_IRQCTL ||
                  paddr == iit_pkg::IIT_OFS_STATUS || paddr == iit_pkg::IIT_OFS_MASK ||
                  paddr == iit_pkg::IIT_OFS_PORTG;

  // ==========================================
  // Clock mode decode
  always_comb begin
    if (!idlePeriodCtrlReg.dualClockEnable) begin
      mode = iit_pkg::IIT_MODE_FAST;
    end else if (idlePeriodCtrlReg.fastOscOn) begin
      mode = iit_pkg::IIT_MODE_DUAL;
    end else begin
      mode = iit_pkg::IIT_MODE_SLOW;
    end
  end

  // Divider runs fast only in high-speed mode
  iit_tick_gen u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .slowSel(mode != iit_pkg::IIT_MODE_FAST), // R2 R3 R4
    .tick(cntTick)
  );

  // ==========================================
  // Idle counter
  assign next_idleCounter = idleCounter - 16'h0001; // R1
  // Tap bit falls 1->0 at underflow of the selected bit
  always_comb begin
    tapUnderflow = 1'b0;
    if (cntTick && idlePeriodCtrlReg.idlePeriodSelect <= iit_pkg::IIT_SEL_MAX) begin // R10
      tapUnderflow = idleCounter[iit_pkg::IIT_TAP_BASE + idlePeriodCtrlReg.idlePeriodSelect] &&
                     !next_idleCounter[iit_pkg::IIT_TAP_BASE + idlePeriodCtrlReg.idlePeriodSelect]; // R5
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idleCounter <= iit_pkg::IIT_COUNT_RST;
    end else if (cntTick) begin
      idleCounter <= next_idleCounter; // R1
    end
  end

  // ==========================================
  // Period control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idlePeriodCtrlReg <= iit_pkg::IIT_PERIOD_RST; // R11
    end else if (wrEn && paddr == iit_pkg::IIT_OFS_PERIOD && pstrb[0]) begin
      idlePeriodCtrlReg <= pwdata[7:0]; // R14
      idlePeriodCtrlReg.rsvd <= 1'b0; // R12
    end
  end

  // Zero write to clock-mode bits requests a device reset
  assign resetEvent = wrEn && paddr == iit_pkg::IIT_OFS_PERIOD && pstrb[0] && pwdata[7:4] == 4'h0; // R13

  // ==========================================
  // Interrupt control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqControlReg <= iit_pkg::IIT_IRQCTL_RST;
    end else begin
      if (wrEn && paddr == iit_pkg::IIT_OFS_IRQCTL && pstrb[0]) begin
        irqControlReg <= pwdata[7:0];
      end
      if (tapUnderflow) begin
        irqControlReg[iit_pkg::IIT_BIT_PENDING] <= 1'b1; // R6 R16 R9
      end
    end
  end

  // ==========================================
  // Port G data register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      portGData <= iit_pkg::IIT_PORTG_RST;
    end else begin
      if (wrEn && paddr == iit_pkg::IIT_OFS_PORTG && pstrb[0]) begin
        portGData <= pwdata[7:0];
      end
      if (tapUnderflow) begin
        portGData[iit_pkg::IIT_BIT_WAKE] <= 1'b0; // R7
      end
    end
  end

  // ==========================================
  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status <= 2'h0;
      mask <= 2'h0;
    end else begin
      if (wrEn && paddr == iit_pkg::IIT_OFS_MASK && pstrb[0]) begin
        mask <= pwdata[1:0];
      end
      status <= (status & ~((wrEn && paddr == iit_pkg::IIT_OFS_STATUS && pstrb[0]) ? pwdata[1:0] : 2'h0)) |
                {resetEvent, tapUnderflow};
    end
  end

  // ==========================================
  // Start-up delay and watchdog time base
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      startupCnt <= 5'h00;
      startupDone <= 1'b0;
      watchdogTick <= 1'b0;
    end else begin
      watchdogTick <= tapUnderflow; // R15
      if (tapUnderflow && !startupDone) begin
        startupCnt <= startupCnt + 5'h01;
      end
      startupDone <= startupDone || (tapUnderflow && startupCnt != 5'h00); // R15
    end
  end

  // ==========================================
  // Outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
      idleTickIrq <= 1'b0;
      wakeBit <= 1'b1;
      deviceResetReq <= 1'b0;
    end else begin
      idleTickIrq <= irqControlReg[iit_pkg::IIT_BIT_PENDING] && irqControlReg[iit_pkg::IIT_BIT_IRQEN] &&
                     irqControlReg[iit_pkg::IIT_BIT_GIE]; // R8
      irq <= |(status & mask);
      wakeBit <= portGData[iit_pkg::IIT_BIT_WAKE];
      deviceResetReq <= resetEvent; // R13
    end
  end

  // ==========================================
  // APB slave: no wait states, read data captured in setup
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rdEn) begin
        case (paddr)
          iit_pkg::IIT_OFS_PERIOD: prdata <= {24'h00_0000, idlePeriodCtrlReg};
          iit_pkg::IIT_OFS_IRQCTL: prdata <= {24'h00_0000, irqControlReg};
          iit_pkg::IIT_OFS_STATUS: prdata <= {30'h0000_0000, status};
          iit_pkg::IIT_OFS_MASK: prdata <= {30'h0000_0000, mask};
          iit_pkg::IIT_OFS_PORTG: prdata <= {24'h00_0000, portGData};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================
  // Assertions
  AST_PEND_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    tapUnderflow |=> irqControlReg[iit_pkg::IIT_BIT_PENDING]) // R6
    else $error("pending not set on underflow");
  AST_WAKE_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    tapUnderflow |=> !portGData[iit_pkg::IIT_BIT_WAKE] ##1 !wakeBit) // R7
    else $error("wake bit not cleared");
  AST_IRQ_AND: assert property (@(posedge clk_sys) disable iff (!rstn)
    idleTickIrq == $past(irqControlReg[5] && irqControlReg[4] && irqControlReg[0])) // R8
    else $error("idle irq gating wrong");
  AST_RSVD_SEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    idlePeriodCtrlReg.idlePeriodSelect > iit_pkg::IIT_SEL_MAX |-> !tapUnderflow) // R10
    else $error("underflow on reserved code");
  AST_RSVD_BIT: assert property (@(posedge clk_sys) disable iff (!rstn) !idlePeriodCtrlReg.rsvd) // R12
    else $error("reserved bit set");
  AST_RESET_REQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    resetEvent |=> deviceResetReq ##1 status[iit_pkg::IIT_ST_RESETREQ]) // R13
    else $error("reset request missing");
  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
    cntTick |=> idleCounter == $past(idleCounter) - 16'h0001) // R1
    else $error("counter did not step");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cntTick |=> idleCounter == $past(idleCounter)) // R2
    else $error("counter moved without tick");
  AST_PEND_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    irqControlReg[5] && !(wrEn && paddr == iit_pkg::IIT_OFS_IRQCTL) |=> irqControlReg[5]) // R16
    else $error("pending dropped");
  AST_WD: assert property (@(posedge clk_sys) disable iff (!rstn) tapUnderflow |=> watchdogTick) // R15
    else $error("watchdog tick missing");
  COV_UNDERFLOW: cover property (@(posedge clk_sys) disable iff (!rstn) tapUnderflow);
  COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(idleTickIrq));
  COV_RESET: cover property (@(posedge clk_sys) disable iff (!rstn) deviceResetReq);
endmodule : idle_interval_timer
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench of the idle interval timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic idleTickIrq;
  logic wakeBit;
  logic deviceResetReq;
  logic watchdogTick;
  logic startupDone;
  logic [31:0] rdVal;
  logic errVal;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int tStamp = 0;
  int slowTicks = 0;
  int resetPulses = 0;
  // ==========================================
  // Clock, design and timeout
  always #50 clk_sys = ~clk_sys;
  idle_interval_timer dut_u (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(4'hF),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .idleTickIrq(idleTickIrq),
    .wakeBit(wakeBit),
    .deviceResetReq(deviceResetReq),
    .watchdogTick(watchdogTick),
    .startupDone(startupDone)
  );
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles >= 100000) begin
      bad_count++;
      print_verdict();
    end
  end
  always @(negedge clk_sys) begin
    if (deviceResetReq === 1'b1) begin
      resetPulses++;
    end
  end
  // ==========================================
  // Tasks
  task print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck transfer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdVal, errVal);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, rdVal, errVal);
    chk(rdVal, e);
  endtask : rdc
  // Wait for the pulse that follows a tap underflow
  task waitTick;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (watchdogTick !== 1'b1 && n < 25000);
    if (n >= 25000) begin
      bad_count++;
    end
  endtask : waitTick
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    chk({31'h0, wakeBit}, 32'h0000_0001);
    rdc(iit_pkg::IIT_OFS_PERIOD, 32'h0000_00F0);
    rdc(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0000);
    rdc(iit_pkg::IIT_OFS_STATUS, 32'h0000_0000);
    rdc(iit_pkg::IIT_OFS_MASK, 32'h0000_0000);
    rdc(iit_pkg::IIT_OFS_PORTG, 32'h0000_00FF);
    rdc(12'h020, 32'h0000_0000);
    chk({31'h0, errVal}, 32'h0000_0001);
    // High-speed mode with clock-mode bits non-zero, reserved bit written high
    wr(iit_pkg::IIT_OFS_PERIOD, 32'h0000_00C8);
    rdc(iit_pkg::IIT_OFS_PERIOD, 32'h0000_00C0);
    wr(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0011);
    wr(iit_pkg::IIT_OFS_MASK, 32'h0000_0001);
    chk({31'h0, idleTickIrq}, 32'h0000_0000);
    waitTick();
    tStamp = cycles;
    repeat (2) @(negedge clk_sys);
    chk({31'h0, idleTickIrq}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({31'h0, wakeBit}, 32'h0000_0000);
    chk({31'h0, startupDone}, 32'h0000_0000);
    rdc(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0031);
    rdc(iit_pkg::IIT_OFS_PORTG, 32'h0000_00BF);
    rdc(iit_pkg::IIT_OFS_STATUS, 32'h0000_0001);
    // Clear pending, then the status bit
    wr(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0011);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, idleTickIrq}, 32'h0000_0000);
    wr(iit_pkg::IIT_OFS_STATUS, 32'h0000_0001);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    // Global enable off: pending sets but no idle tick request
    wr(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0010);
    waitTick();
    chk(32'(cycles - tStamp), 32'h0000_5000);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, idleTickIrq}, 32'h0000_0000);
    chk({31'h0, startupDone}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(iit_pkg::IIT_OFS_IRQCTL, 32'h0000_0030);
    wr(iit_pkg::IIT_OFS_MASK, 32'h0000_0000);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    // Low-speed mode: far slower tick, no underflow soon
    wr(iit_pkg::IIT_OFS_PERIOD, 32'h0000_00A0);
    repeat (22000) begin
      @(negedge clk_sys);
      if (watchdogTick === 1'b1) begin
        slowTicks++;
      end
    end
    chk(32'(slowTicks), 32'h0000_0000);
    chk(32'(resetPulses), 32'h0000_0000);
    wr(iit_pkg::IIT_OFS_PERIOD, 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
    chk(32'(resetPulses), 32'h0000_0001);
    rdc(iit_pkg::IIT_OFS_STATUS, 32'h0000_0003);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
